// file: rtl/gfx_pci_config_header_ids.v
`timescale 1ns/100ps
`include "gfx_cfg_regs.vh"
module gfx_pci_config_header_ids (
    input wire clock, // Device clock
    input wire rst_b, // Async reset, active low
    input wire cfg_rd, // Config read strobe
    input wire cfg_wr, // Config write strobe, ignored
    input wire [7:0] cfg_addr, // Config byte offset
    input wire [7:0] cfg_wdata, // Write data, ignored
    output reg [7:0] cfg_rdata, // Read data, registered
    output reg cfg_hit // Offset in range, registered
);
    // =====================================
    // Sizes and hardwired fields
    localparam ENTRY_COUNT = 8;
    localparam STATUS_BITS = 16;
    localparam [1:0] SELECT_TIMING = `VAL_SELECT_TIMING;

    // =====================================
    // Status bit table
    function status_bit;
        input integer pos;
        begin
            case (pos)
                `POS_PARITY_ERROR_DETECTED: begin
                    status_bit = 1'b0; // R1
                end

                `POS_SYSTEM_ERROR_SIGNALED: begin
                    status_bit = 1'b0; // R2
                end

                `POS_MASTER_ABORT_RECEIVED: begin
                    status_bit = 1'b0; // R3
                end

                `POS_TARGET_ABORT_RECEIVED: begin
                    status_bit = 1'b0; // R4
                end

                `POS_TARGET_ABORT_SIGNALED: begin
                    status_bit = 1'b0; // R5
                end

                `POS_SELECT_TIMING_HI: begin
                    status_bit = SELECT_TIMING[1]; // R6
                end

                `POS_SELECT_TIMING_LO: begin
                    status_bit = SELECT_TIMING[0]; // R6
                end

                `POS_DATA_PARITY_FLAG: begin
                    status_bit = 1'b0; // R7
                end

                `POS_BACK_TO_BACK_CAPABLE: begin
                    status_bit = 1'b1; // R8
                end

                `POS_USER_FORMAT: begin
                    status_bit = 1'b0; // R9
                end

                `POS_HIGH_SPEED_CAPABLE: begin
                    status_bit = 1'b1; // R10
                end

                `POS_CAP_LIST: begin
                    status_bit = 1'b1; // R11
                end

                default: begin
                    status_bit = 1'b0; // R19
                end
            endcase
        end
    endfunction

    // =====================================
    // Whole status word, assembled bit by bit
    function [15:0] status_word;
        input integer width;
        integer b;
        begin
            status_word = 16'h0000;
            for (b = 0; b < width; b = b + 1) begin
                status_word[b] = status_bit(b);
            end
        end
    endfunction

    localparam [15:0] STATUS_INIT = status_word(STATUS_BITS);

    // =====================================
    // Byte offset of each entry
    function [7:0] entry_offset;
        input integer idx;
        begin
            case (idx)
                0: begin
                    entry_offset = `OFS_PCI_STATUS_LO;
                end

                1: begin
                    entry_offset = `OFS_PCI_STATUS_HI;
                end

                2: begin
                    entry_offset = `OFS_REVISION_CODE;
                end

                3: begin
                    entry_offset = `OFS_PROG_IF;
                end

                4: begin
                    entry_offset = `OFS_SUB_CLASS;
                end

                5: begin
                    entry_offset = `OFS_BASE_CLASS;
                end

                6: begin
                    entry_offset = `OFS_LINE_SIZE_CACHE;
                end

                7: begin
                    entry_offset = `OFS_BUS_LATENCY;
                end

                default: begin
                    entry_offset = 8'hff;
                end
            endcase
        end
    endfunction

    // =====================================
    // Contents loaded at reset
    function [7:0] reset_byte;
        input integer idx;
        begin
            case (idx)
                0: begin
                    reset_byte = STATUS_INIT[7:0];
                end

                1: begin
                    reset_byte = STATUS_INIT[15:8];
                end

                2: begin
                    reset_byte = {`RST_REV_PROCESS, `RST_REV_STEPPING}; // R12
                end

                3: begin
                    reset_byte = `RST_PROG_IF; // R14
                end

                4: begin
                    reset_byte = `RST_SUB_CLASS; // R15
                end

                5: begin
                    reset_byte = `RST_BASE_CLASS; // R16
                end

                6: begin
                    reset_byte = `RST_LINE_SIZE_CACHE; // R17
                end

                7: begin
                    reset_byte = `RST_BUS_LATENCY; // R18
                end

                default: begin
                    reset_byte = 8'h00;
                end
            endcase
        end
    endfunction

    // =====================================
    // Bits that a write may change: none in this range
    function [7:0] write_mask;
        input integer idx;
        begin
            case (idx)
                0: begin
                    write_mask = 8'h00; // R19
                end

                1: begin
                    write_mask = 8'h00; // R19
                end

                2: begin
                    write_mask = 8'h00; // R13
                end

                3: begin
                    write_mask = 8'h00; // R19
                end

                4: begin
                    write_mask = 8'h00; // R19
                end

                5: begin
                    write_mask = 8'h00; // R19
                end

                6: begin
                    write_mask = 8'h00; // R19
                end

                7: begin
                    write_mask = 8'h00; // R18
                end

                default: begin
                    write_mask = 8'h00;
                end
            endcase
        end
    endfunction

    // =====================================
    // Storage and decode nets
    wire [ENTRY_COUNT-1:0] select_w;
    wire [8*ENTRY_COUNT-1:0] masked_w;
    reg [7:0] rd_d;
    reg hit_d;
    reg [7:0] rdata_d;
    reg hit_out_d;
    integer m;

    // =====================================
    // One flip-flop byte per entry
    // Masked write path kept so a writable bit needs only one table entry
    genvar e;
    generate
        for (e = 0; e < ENTRY_COUNT; e = e + 1) begin : slot
            localparam [7:0] INIT = reset_byte(e);
            localparam [7:0] WMASK = write_mask(e);
            reg [7:0] byte_q;
            reg [7:0] byte_d;
            always @* begin
                byte_d = byte_q;
                if (cfg_wr && select_w[e]) begin
                    byte_d = (byte_q & ~WMASK) | (cfg_wdata & WMASK); // R13 R19
                end
            end
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    byte_q <= INIT;
                end else begin
                    byte_q <= byte_d;
                end
            end
            assign select_w[e] = (cfg_addr == entry_offset(e));
            assign masked_w[8*e +: 8] = byte_q & {8{select_w[e]}};
        end
    endgenerate

    // =====================================
    // Read decode; offsets are unique, so an OR of masked bytes forms the mux
    always @* begin
        rd_d = 8'h00;
        hit_d = 1'b0;
        for (m = 0; m < ENTRY_COUNT; m = m + 1) begin
            rd_d = rd_d | masked_w[8*m +: 8];
            hit_d = hit_d | select_w[m];
        end
    end

    // =====================================
    // Answer stands one cycle only; an idle bus reads back zero
    always @* begin
        rdata_d = 8'h00;
        hit_out_d = 1'b0;
        if (cfg_rd) begin
            rdata_d = rd_d;
            hit_out_d = hit_d;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata <= 8'h00;
        end else begin
            cfg_rdata <= rdata_d; // R19
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_hit <= 1'b0;
        end else begin
            cfg_hit <= hit_out_d;
        end
    end
endmodule

// file: rtl/gfx_cfg_regs.vh
// Behaviour
// R1 - Status bit 15 parity error reads zero
// R2 - Status bit 14 system error reads zero
// R3 - Status bit 13 master abort reads zero
// R4 - Status bit 12 target abort reads zero
// R5 - Status bit 11 signaled abort reads zero
// R6 - Status bits 10:9 select timing read 01
// R7 - Status bit 8 data parity reads zero
// R8 - Status bit 7 back-to-back reads one
// R9 - Status bit 6 user format reads zero
// R10 - Status bit 5 high speed reads one
// R11 - Status bit 4 capability list reads one
// R12 - Revision code: process high, stepping low
// R13 - Writes to revision code are discarded
// R14 - Programming interface reads 00h
// R15 - Sub-class code reads 00h
// R16 - Base class code reads 03h
// R17 - Cache line size reads zero
// R18 - Latency timer reads zero, not programmable
// R19 - Writes ignored; status bits 3:0 zero
`ifndef GFX_CFG_REGS_VH
`define GFX_CFG_REGS_VH
// =====================================
// Offsets
`define OFS_PCI_STATUS_LO 8'h06
`define OFS_PCI_STATUS_HI 8'h07
`define OFS_REVISION_CODE 8'h08
`define OFS_PROG_IF 8'h09
`define OFS_SUB_CLASS 8'h0a
`define OFS_BASE_CLASS 8'h0b
`define OFS_LINE_SIZE_CACHE 8'h0c
`define OFS_BUS_LATENCY 8'h0d
// =====================================
// Status field positions
`define POS_PARITY_ERROR_DETECTED 15
`define POS_SYSTEM_ERROR_SIGNALED 14
`define POS_MASTER_ABORT_RECEIVED 13
`define POS_TARGET_ABORT_RECEIVED 12
`define POS_TARGET_ABORT_SIGNALED 11
`define POS_SELECT_TIMING_HI 10
`define POS_SELECT_TIMING_LO 9
`define POS_DATA_PARITY_FLAG 8
`define POS_BACK_TO_BACK_CAPABLE 7
`define POS_USER_FORMAT 6
`define POS_HIGH_SPEED_CAPABLE 5
`define POS_CAP_LIST 4
// =====================================
// Values
`define VAL_SELECT_TIMING 2'h1
`define RST_PCI_STATUS 16'h02b0
`define RST_PROG_IF 8'h00
`define RST_SUB_CLASS 8'h00
`define RST_BASE_CLASS 8'h03
`define RST_LINE_SIZE_CACHE 8'h00
`define RST_BUS_LATENCY 8'h00
// Arbitrary neutral revision value
`define RST_REVISION_CODE 8'h11
// Arbitrary nibbles, kept equal to the full code above
`define RST_REV_PROCESS 4'h1
`define RST_REV_STEPPING 4'h1
`endif

// file: tb/cfg_ids_sva.sv
`timescale 1ns/100ps
`include "gfx_cfg_regs.vh"
module cfg_ids_sva (
    input wire clock, // Clock
    input wire rst_b, // Reset
    input wire cfg_rd, // Read
    input wire [7:0] cfg_addr, // Offset
    input wire [7:0] cfg_rdata, // Data
    input wire cfg_hit // Hit
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property rd_p(a, v);
        cfg_rd && cfg_addr == a |=> cfg_hit && cfg_rdata == v;
    endproperty
    chk_stat_lo: assert property (rd_p(8'h06, 8'hb0)) else $error("bad");
    chk_stat_hi: assert property (rd_p(8'h07, 8'h02)) else $error("bad");
    chk_rev_code: assert property (rd_p(8'h08, `RST_REVISION_CODE)) else $error("bad");
    chk_prog_if: assert property (rd_p(8'h09, 8'h00)) else $error("bad");
    chk_sub_class: assert property (rd_p(8'h0a, 8'h00)) else $error("bad");
    chk_base_class: assert property (rd_p(8'h0b, 8'h03)) else $error("bad");
    chk_line_size: assert property (rd_p(8'h0c, 8'h00)) else $error("bad");
    chk_bus_latency: assert property (rd_p(8'h0d, 8'h00)) else $error("bad");
    chk_idle_quiet: assert property (!cfg_rd |=> !cfg_hit && cfg_rdata == 8'h00) else $error("bad");
    chk_out_range: assert property (cfg_rd && (cfg_addr < 8'h06 || cfg_addr > 8'h0d)
        |=> !cfg_hit && cfg_rdata == 8'h00) else $error("bad");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
`include "gfx_cfg_regs.vh"
module tb_top;
    logic clock = 1'b0, rst_b = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0, cfg_hit;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'hff, cfg_rdata;
    logic [8:0] exp_v [0:9] = '{9'h000, 9'h1b0, 9'h102, {1'b1, `RST_REVISION_CODE},
        9'h100, 9'h100, 9'h103, 9'h100, 9'h100, 9'h000};
    int mismatches = 0, tests_run = 0;
    gfx_pci_config_header_ids u_gfx_pci_config_header_ids (.clock(clock), .rst_b(rst_b),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit));
    initial forever #50 clock = ~clock;
    task automatic rd(input int i);
        @(posedge clock) cfg_rd <= 1'b1;
        cfg_addr <= 8'(5 + i);
        @(posedge clock) cfg_rd <= 1'b0;
        @(negedge clock) tests_run++;
        if ({cfg_hit, cfg_rdata} !== exp_v[i]) begin
            mismatches++;
            $display("mismatch %0t %h %h", $time, {cfg_hit, cfg_rdata}, exp_v[i]);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            // Second pass: writes back to back, then the same values must return
            for (int i = 0; i < 10 && k; i++) begin
                @(posedge clock) cfg_wr <= 1'b1;
                cfg_addr <= 8'(5 + i);
            end
            @(posedge clock) cfg_wr <= 1'b0;
            for (int i = 0; i < 10; i++) rd(i);
            $display("test %0d done", k);
        end
        print_verdict();
    end
    initial begin
        #20000 mismatches++;
        print_verdict();
    end
endmodule
bind gfx_pci_config_header_ids cfg_ids_sva u_cfg_ids_sva (.clock(clock), .rst_b(rst_b),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit));
